// >>> include/smbus_temp_defines.vh
// constants for the smbus temperature readout block
// assumes: included by bare name from the design files, 50 MHz system clock
`ifndef SMBUS_TEMP_DEFINES_VH
`define SMBUS_TEMP_DEFINES_VH

// ***********************************
// addressing and register offsets
// ***********************************
`define TGT_ADDR        7'h2f
`define REG_CH1_TEMP    8'h00
`define REG_CH2_TEMP    8'h01
`define REG_CH1_FRAC    8'h05
`define REG_CH2_FRAC    8'h06
`define REG_SCRATCH     8'h07
`define SEL_RESET       8'h00
`define SCRATCH_RESET   8'h00

// ***********************************
// timing
// ***********************************
`define CLK_HZ          50000000
`define CONV_HZ         4
`define CONV_CYCLES     (`CLK_HZ / `CONV_HZ)
`define HOLD_MS         250
`define HOLD_CYCLES     ((`CLK_HZ / 1000) * `HOLD_MS)

`endif

// >>> verilog/pin_sync.v
// two-flop synchroniser for a bundle of asynchronous pins
// assumes: inputs are idle high (pulled-up smbus lines)
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // first stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// >>> verilog/temp_store.v
// temperature result store with conversion timer and read lock
// assumes: raw readings are signed, 1/8 degree lsb, 12 bits per channel
`timescale 1ns/1ps
`default_nettype none
`include "smbus_temp_defines.vh"
module temp_store #(
  parameter CONV_CYCLES = `CONV_CYCLES,
  parameter HOLD_CYCLES = `HOLD_CYCLES
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [11:0] raw_ch1,
  input  wire [11:0] raw_ch2,
  input  wire [1:0]  rd_int,
  input  wire [1:0]  rd_frac,
  output wire [7:0]  int_ch1,
  output wire [7:0]  int_ch2,
  output wire [7:0]  frac_ch1,
  output wire [7:0]  frac_ch2,
  output wire        conv_tick
);
  reg  [31:0] conv_cnt_reg;
  reg  [7:0]  int_reg  [0:1];
  reg  [7:0]  frac_reg [0:1];
  wire [11:0] raw      [0:1];

  assign raw[0]    = raw_ch1;
  assign raw[1]    = raw_ch2;
  assign conv_tick = (conv_cnt_reg == CONV_CYCLES - 1);

  // free-running 4 Hz schedule from reset release
  always @(posedge clk or posedge rst) begin
    if (rst)
      conv_cnt_reg <= 32'h0;
    else if (conv_tick)
      conv_cnt_reg <= 32'h0;
    else
      conv_cnt_reg <= conv_cnt_reg + 32'h1;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      reg        lock_reg;
      reg [31:0] hold_cnt_reg;
      wire       neg = raw[ch][11];
      wire       hold_done = (hold_cnt_reg >= HOLD_CYCLES);

      // lock: fraction read freezes integer; integer read releases
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          lock_reg     <= 1'b0;
          hold_cnt_reg <= 32'h0;
        end else if (rd_frac[ch]) begin
          lock_reg     <= 1'b1;
          hold_cnt_reg <= 32'h0;
        end else begin
          if (rd_int[ch])
            lock_reg <= 1'b0;
          else if (conv_tick && hold_done)
            lock_reg <= 1'b0;
          if (!hold_done)
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
      end

      // integer kept frozen while locked until the hold has run out, fraction always follows
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          int_reg[ch]  <= 8'h00;
          frac_reg[ch] <= 8'h00;
        end else if (conv_tick) begin
          if (!lock_reg || (hold_done && !rd_frac[ch]))
            int_reg[ch] <= neg ? 8'h00 : raw[ch][10:3];
          frac_reg[ch] <= neg ? 8'h00 : {raw[ch][2:0], 5'h00};
        end
      end
    end
  endgenerate

  assign int_ch1  = int_reg[0];
  assign int_ch2  = int_reg[1];
  assign frac_ch1 = frac_reg[0];
  assign frac_ch2 = frac_reg[1];
endmodule
`default_nettype wire

// >>> verilog/smbus_temp_target.v
// smbus target for the temperature readout registers
// assumes: SCL/SDA are async pins pulled up outside; SDA is open drain
`timescale 1ns/1ps
`default_nettype none
`include "smbus_temp_defines.vh"
module smbus_temp_target #(
  parameter CONV_CYCLES = `CONV_CYCLES,
  parameter HOLD_CYCLES = `HOLD_CYCLES
) (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        SCL,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  input  wire [11:0] RAW_CH1,
  input  wire [11:0] RAW_CH2,
  output wire        CONV_TICK,
  output wire [7:0]  SCRATCH
);
  // ***********************************
  // states
  // ***********************************
  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_ADDR  = 6'h02;
  localparam [5:0] ST_ACK   = 6'h04;
  localparam [5:0] ST_RX    = 6'h08;
  localparam [5:0] ST_TX    = 6'h10;
  localparam [5:0] ST_RACK  = 6'h20;

  reg  [5:0] state_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg        rw_reg;
  reg        got_cmd_reg;
  reg        addr_seen_reg;
  reg  [7:0] sel_reg;
  reg  [7:0] scratch_reg;
  reg        sda_low_reg;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg  [1:0] rd_int_reg;
  reg  [1:0] rd_frac_reg;
  wire [1:0] pins;
  wire       scl_s;
  wire       sda_s;
  wire [7:0] int_ch1;
  wire [7:0] int_ch2;
  wire [7:0] frac_ch1;
  wire [7:0] frac_ch2;
  reg  [7:0] rd_data;

  // ***********************************
  // pin sampling
  // ***********************************
  pin_sync #(.W(2)) u_sync (
    .clk      (CLK_SYS),
    .rst      (RST),
    .async_in ({SCL, SDA_IN}),
    .sync_out (pins)
  );
  assign scl_s = pins[1];
  assign sda_s = pins[0];

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;  // also repeated start
  wire stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ***********************************
  // result store
  // ***********************************
  temp_store #(
    .CONV_CYCLES (CONV_CYCLES),
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_store (
    .clk       (CLK_SYS),
    .rst       (RST),
    .raw_ch1   (RAW_CH1),
    .raw_ch2   (RAW_CH2),
    .rd_int    (rd_int_reg),
    .rd_frac   (rd_frac_reg),
    .int_ch1   (int_ch1),
    .int_ch2   (int_ch2),
    .frac_ch1  (frac_ch1),
    .frac_ch2  (frac_ch2),
    .conv_tick (CONV_TICK)
  );

  // read mux; unmapped selections read as zero
  always @* begin
    rd_data = 8'h00;
    if (sel_reg == `REG_CH1_TEMP)
      rd_data = int_ch1;
    else if (sel_reg == `REG_CH2_TEMP)
      rd_data = int_ch2;
    else if (sel_reg == `REG_CH1_FRAC)
      rd_data = frac_ch1;
    else if (sel_reg == `REG_CH2_FRAC)
      rd_data = frac_ch2;
    else if (sel_reg == `REG_SCRATCH)
      rd_data = scratch_reg;
  end

  // ***********************************
  // protocol engine
  // ***********************************
  // ack and data change only on scl low, so the host never sees a false start/stop
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
      rw_reg      <= 1'b0;
      got_cmd_reg <= 1'b0;
      addr_seen_reg <= 1'b0;
      sel_reg     <= `SEL_RESET;
      scratch_reg <= `SCRATCH_RESET;
      sda_low_reg <= 1'b0;
      rd_int_reg  <= 2'b00;
      rd_frac_reg <= 2'b00;
    end else begin
      rd_int_reg  <= 2'b00;
      rd_frac_reg <= 2'b00;
      if (stop_c) begin
        state_reg   <= ST_IDLE;
        sda_low_reg <= 1'b0;
      end else if (start_c) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 3'h0;
        got_cmd_reg <= 1'b0;
        addr_seen_reg <= 1'b0;
        sda_low_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_low_reg <= 1'b0;
          end
          ST_ADDR: begin
            // the clock fall that closes the start itself must not end the byte
            if (scl_rise) begin
              shift_reg     <= {shift_reg[6:0], sda_s};
              bit_cnt_reg   <= bit_cnt_reg + 3'h1;
              addr_seen_reg <= 1'b1;
            end else if (scl_fall && bit_cnt_reg == 3'h0 && addr_seen_reg) begin
              // full byte in; only our fixed address is answered
              if (shift_reg[7:1] == `TGT_ADDR) begin
                rw_reg      <= shift_reg[0];
                sda_low_reg <= 1'b1;
                state_reg   <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_low_reg <= 1'b0;
              bit_cnt_reg <= 3'h0;
              if (rw_reg) begin
                // read byte / receive byte: last selection answers
                shift_reg   <= {rd_data[6:0], 1'b0};
                sda_low_reg <= ~rd_data[7];
                bit_cnt_reg <= 3'h1;
                state_reg   <= ST_TX;
                if (sel_reg == `REG_CH1_FRAC)
                  rd_frac_reg <= 2'b01;
                else if (sel_reg == `REG_CH2_FRAC)
                  rd_frac_reg <= 2'b10;
                else if (sel_reg == `REG_CH1_TEMP)
                  rd_int_reg <= 2'b01;
                else if (sel_reg == `REG_CH2_TEMP)
                  rd_int_reg <= 2'b10;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end else if (scl_fall && bit_cnt_reg == 3'h0) begin
              sda_low_reg <= 1'b1;
              state_reg   <= ST_ACK;
              if (!got_cmd_reg) begin
                sel_reg     <= shift_reg;
                got_cmd_reg <= 1'b1;
              end else if (sel_reg == `REG_SCRATCH) begin
                scratch_reg <= shift_reg;
              end
            end
          end
          ST_TX: begin
            // msb went out at the ack fall; shift the rest on each fall
            if (scl_fall) begin
              if (bit_cnt_reg == 3'h0) begin
                sda_low_reg <= 1'b0;
                state_reg   <= ST_RACK;
              end else begin
                sda_low_reg <= ~shift_reg[7];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
              end
            end
          end
          ST_RACK: begin
            // host nack ends the read; an ack gets the same register again
            if (scl_rise) begin
              if (sda_s)
                state_reg <= ST_IDLE;
              else
                state_reg <= ST_ACK;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = sda_low_reg;
  assign SCRATCH = scratch_reg;
endmodule
`default_nettype wire

// >>> verilog/dummy_unused_placeholder_never.v
`timescale 1ns/1ps

// >>> tb/smbus_temp_target_sva.sv
// pin checks for the smbus temperature target
// assumes: bound to smbus_temp_target, scl low for four clocks
`timescale 1ns/1ps
`default_nettype none
module smbus_temp_target_sva #(
  parameter CONV_CYCLES = 200
) (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       SCL,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic       CONV_TICK,
  input wire logic [7:0] SCRATCH
);
  // ****************
  // checks
  // ****************
  // clocks since the last tick, mirrors the timer
  int unsigned cnt;
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) cnt <= 0;
    else cnt <= CONV_TICK ? 0 : cnt + 1;
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // device starts pulling the data line
  sequence s_drive_on;
    $rose(SDA_OE);
  endsequence
  a_tick_on_time: assert property (CONV_TICK |-> cnt == CONV_CYCLES - 1)
    else $error("tick off schedule");
  a_tick_not_late: assert property (cnt < CONV_CYCLES)
    else $error("tick missing");
  a_tick_single: assert property (CONV_TICK |=> !CONV_TICK)
    else $error("tick too long");
  a_oe_holds: assert property (s_drive_on |=> SDA_OE [*4])
    else $error("drive too short");
  // data may only move while scl is low, else it forms a start or stop
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL)
    else $error("sda moved with scl high");
  a_start_free: assert property ($fell(SDA_IN) && SCL |-> !SDA_OE)
    else $error("driving at start");
  a_sda_out_low: assert property (SDA_OUT == 1'b0)
    else $error("sda driven high");
  a_rst_quiet: assert property (disable iff (1'b0) RST |-> !SDA_OE && SCRATCH == 8'h00)
    else $error("busy in reset");
endmodule
`default_nettype wire

// >>> tb/smbus_host_model.sv
// smbus host controller, single master, pulls sda low only
// assumes: sda wire has a pull-up, steps on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  input  wire logic clk,
  output var logic  scl,
  output var logic  sda_pull,
  input  wire logic sda
);
  // ****************
  // bus phases
  // ****************
  // idle bus: both lines released, clock stands high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // quarter of a 160 ns scl period
  task automatic q();
    repeat (2) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  // also serves as repeated start
  task automatic start();
    sda_pull = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // one byte only, so always nack it
  task automatic rd(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, r);
  endtask
endmodule
`default_nettype wire

// >>> tb/test_smbus_temperature_readout.sv
// bench for the smbus temperature target
// assumes: host model on the far side, short timer counts
`timescale 1ns/1ps
`default_nettype none
module test_smbus_temperature_readout;
  localparam CONV = 200;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b0;
  logic [11:0] raw_ch1 = 12'd204;
  logic [11:0] raw_ch2 = 12'hfd8;
  wire         scl, pull, sda_out, sda_oe, conv_tick;
  wire [7:0]   scratch;
  wire         sda = !(pull | (sda_oe & !sda_out));
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [7:0]  d;
  smbus_temp_target #(.CONV_CYCLES(CONV), .HOLD_CYCLES(1000)) smbus_temp_target_i (
    .CLK_SYS(clk_sys), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .RAW_CH1(raw_ch1), .RAW_CH2(raw_ch2), .CONV_TICK(conv_tick),
    .SCRATCH(scratch));
  smbus_host_model smbus_host_model_i (.clk(clk_sys), .scl(scl), .sda_pull(pull), .sda(sda));
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic ok);
    logic a;
    smbus_host_model_i.wr(b, a);
    chk({7'h00, a}, {7'h00, ok});
  endtask
  task automatic addr_cmd(input logic [7:0] c);
    smbus_host_model_i.start();
    put(8'h5e, 1'b1);
    put(c, 1'b1);
  endtask
  task automatic recv_reg(output logic [7:0] v);
    smbus_host_model_i.start();
    put(8'h5f, 1'b1);
    smbus_host_model_i.rd(v);
    smbus_host_model_i.stop();
  endtask
  task automatic read_reg(input logic [7:0] c, output logic [7:0] v);
    addr_cmd(c);
    recv_reg(v);
  endtask
  task automatic write_reg(input logic [7:0] c, input logic [7:0] v);
    addr_cmd(c);
    put(v, 1'b1);
    smbus_host_model_i.stop();
  endtask
  // bounded wait for the next conversion
  task automatic wait_tick();
    for (int n = 0; n < 2 * CONV && !conv_tick; n++) @(negedge clk_sys);
    chk({7'h00, conv_tick}, 8'h01);
    @(negedge clk_sys);
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************
  // run
  // ****************
  always #10 clk_sys = ~clk_sys;
  // hang guard, far above the few thousand cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    wait_tick();
    read_reg(8'h00, d);
    chk(d, 8'h19);
    read_reg(8'h01, d);
    chk(d, 8'h00);
    read_reg(8'h06, d);
    chk(d, 8'h00);
    addr_cmd(8'h05);
    smbus_host_model_i.stop();
    recv_reg(d);
    chk(d, 8'h80);
    raw_ch1 = 12'd240;
    wait_tick();
    read_reg(8'h00, d);
    chk(d, 8'h19);
    wait_tick();
    read_reg(8'h00, d);
    chk(d, 8'h1e);
    // every single-bit neighbour of the target address is ignored
    for (int i = 0; i < 7; i++) begin
      smbus_host_model_i.start();
      put({7'h2f ^ (7'h01 << i), 1'b0}, 1'b0);
      smbus_host_model_i.stop();
    end
    write_reg(8'h07, 8'ha5);
    chk(scratch, 8'ha5);
    write_reg(8'h00, 8'h55);
    recv_reg(d);
    chk(d, 8'h1e);
    read_reg(8'h07, d);
    chk(d, 8'ha5);
    read_reg(8'h02, d);
    chk(d, 8'h00);
    results();
  end
endmodule
bind smbus_temp_target smbus_temp_target_sva #(.CONV_CYCLES(CONV_CYCLES)) smbus_temp_target_sva_i (
  .CLK_SYS(CLK_SYS), .RST(RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .CONV_TICK(CONV_TICK), .SCRATCH(SCRATCH));
`default_nettype wire
